/* include/fbef_pkg.sv */
// Package of word offsets, bit positions and sizes for the fieldbus axis error flag bank.
// How it works
// - Bit 00 set on slave list mismatch.
// - Bit 01 set on unsupported network shape.
// - Bit 02 set on process data fault.
// - Bit 03 set when missed frames exceed limit.
// - Bit 04 set on parameter check error.
// - Bit 05 set when frame send fails.
// - Bit 09 set when slave link fails.
// - Bit 10 set on duplicate node address.
// - Bit 11 set on slave AL status error.
// - Bit 12 set on slave initialization failure.
// - Bit 14 non-fatal, bit 15 fatal data fault.
// - One latched error bit per node, 80 nodes.
// - Axis busy bit follows axis activity.
// - Axis word bit 08 on sensor fault.
// - Axis word bit 09 on drive alarm.
// - Axis word bit 10 on execution fault.
// - Axis bit 11 warning, bit 12 error.
// - Task busy follows axis or task activity.
// - Task busy word bit 10 on task error.
// - Task fault word: bit 11 warning, 12 error.
// - Matching restart bit restarts the unit.
// - Control bit 00 clears latched errors.
// - Control bit 01 clears latched warnings.
// - Control block at 1500 plus 25 times unit.
`default_nettype none
package fbef_pkg;
    // ----------------------------------------
    // Word offsets
    // ----------------------------------------
    localparam logic [15:0] FBEF_CTRL_BASE = 16'h05DC;
    localparam logic [15:0] FBEF_CTRL_STRIDE = 16'h0019;
    localparam logic [15:0] FBEF_NET_OFS = 16'h0013;
    localparam logic [15:0] FBEF_NODE1_OFS = 16'h0018;
    localparam logic [15:0] FBEF_NODEX_OFS = 16'h0010;
    localparam logic [15:0] FBEF_AXIS_BUSY_OFS = 16'h0002;
    localparam logic [15:0] FBEF_AXIS_FAULT_OFS = 16'h0005;
    localparam logic [15:0] FBEF_AXIS_STRIDE = 16'h000D;
    localparam logic [15:0] FBEF_TASK_BUSY_OFS = 16'h0001;
    localparam logic [15:0] FBEF_TASK_FAULT_OFS = 16'h0002;
    localparam logic [15:0] FBEF_TASK_STRIDE = 16'h0006;
    // ----------------------------------------
    // Bit positions
    // ----------------------------------------
    localparam int FBEF_B_VERIFY = 0;
    localparam int FBEF_B_SHAPE = 1;
    localparam int FBEF_B_PDATA = 2;
    localparam int FBEF_B_TMO = 3;
    localparam int FBEF_B_PARAM = 4;
    localparam int FBEF_B_SEND = 5;
    localparam int FBEF_B_LINK = 9;
    localparam int FBEF_B_DUP = 10;
    localparam int FBEF_B_AL = 11;
    localparam int FBEF_B_INIT = 12;
    localparam int FBEF_B_NONFATAL = 14;
    localparam int FBEF_B_FATAL = 15;
    localparam int FBEF_B_BUSY = 0;
    localparam int FBEF_B_SENSOR = 8;
    localparam int FBEF_B_SERVO = 9;
    localparam int FBEF_B_EXEC = 10;
    localparam int FBEF_B_WARN = 11;
    localparam int FBEF_B_ERR = 12;
    localparam int FBEF_B_ERST = 0;
    localparam int FBEF_B_WRST = 1;
    // ----------------------------------------
    // Sizes and timing
    // ----------------------------------------
    localparam int FBEF_NODES = 80;
    localparam int FBEF_AXES = 4;
    localparam int FBEF_TASKS = 4;
    localparam int FBEF_WORD_W = 16;
    localparam int FBEF_UNITS = 16;
    localparam int FBEF_RESTART_CYC = 16;
endpackage
`default_nettype wire

/* rtl/fbef_latch.sv */
// Sticky flag group that sets on events and clears on a reset request.
`timescale 1ns/1ps
`default_nettype none
module fbef_latch #(
    parameter int W = 1
) (
    input wire logic clock, // Unit clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [W-1:0] set_in, // Event pulses or levels.
    input wire logic clr_in, // Clear request.
    output logic [W-1:0] flag_out // Latched flags.
);
    logic [W-1:0] flag_reg;
    logic [W-1:0] flag_next;

    initial begin
        if (W < 1) $error("fbef_latch width must be at least one");
    end

    // A set arriving with the clear survives so no event is lost.
    assign flag_next = (clr_in ? '0 : flag_reg) | set_in;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag_out = flag_reg;

    a_set_wins: assert property (@(posedge clock) disable iff (!rst_n)
        |set_in |=> ((flag_reg & $past(set_in)) == $past(set_in)))
        else $error("flag event lost");
endmodule
`default_nettype wire

/* rtl/fbef_bank.sv */
// Fieldbus, axis and task error flag bank with word-addressed read port.
`timescale 1ns/1ps
`default_nettype none
module fbef_bank
    import fbef_pkg::*;
#(
    parameter int NODES = fbef_pkg::FBEF_NODES,
    parameter int AXES = fbef_pkg::FBEF_AXES,
    parameter int TASKS = fbef_pkg::FBEF_TASKS,
    parameter logic [3:0] UNIT_NUM = 4'h0,
    parameter logic [15:0] AXIS_BASE = 16'h0100,
    parameter logic [15:0] TASK_BASE = 16'h0200,
    parameter logic [15:0] NODEX_BASE = 16'h0300
) (
    input wire logic clock, // Unit clock, 50 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [15:0] ctrl_word, // Host control word (bit 00 error, 01 warning reset).
    input wire logic [15:0] restart_bits, // Host restart bits, one per unit number.
    input wire logic [15:0] rd_addr, // Word address of host read.
    input wire logic rd_en, // Host read strobe.
    output logic [15:0] rd_data, // Read data, one cycle after strobe.
    output logic rd_hit, // Address matched a mapped word.
    output logic unit_restart, // Restart pulse toward the unit.
    input wire logic [15:0] slaves_cfg, // Registered slave count.
    input wire logic [15:0] slaves_found, // Detected slave count.
    input wire logic shape_bad, // Unsupported topology or slave count.
    input wire logic pdata_fault, // Process data fault.
    input wire logic pdata_fatal, // Process data fault is fatal.
    input wire logic frame_tick, // One pulse per communications cycle.
    input wire logic frame_rx, // Frame received in that cycle.
    input wire logic [7:0] tmo_limit, // Timeout detection count.
    input wire logic param_bad, // Parameter check error.
    input wire logic send_fail, // Frame could not be sent.
    input wire logic link_fail, // Slave link failure.
    input wire logic dup_addr, // Duplicate node address seen.
    input wire logic al_fault, // Slave AL status error.
    input wire logic init_fail, // Slave initialization failure.
    input wire logic [NODES-1:0] node_fault, // Per-node fault events.
    input wire logic [AXES-1:0] axis_busy, // Axis busy levels.
    input wire logic [AXES-1:0] axis_sensor, // External sensor faults.
    input wire logic [AXES-1:0] axis_servo, // Drive alarm faults.
    input wire logic [AXES-1:0] axis_exec, // Execution faults.
    input wire logic [AXES-1:0] axis_warn, // Axis warnings.
    input wire logic [AXES-1:0] axis_err, // Axis errors.
    input wire logic [TASKS*AXES-1:0] task_axes, // Axes belonging to each task.
    input wire logic [TASKS-1:0] task_run, // Task function executing.
    input wire logic [TASKS-1:0] task_exec, // Task function operation error.
    input wire logic [TASKS-1:0] task_warn, // Memory operation warning.
    input wire logic [TASKS-1:0] task_err // Memory operation error.
);
    import fbef_pkg::*;

    initial begin
        if (NODES < 17 || NODES > 80 || NODES % 16 != 0) $error("NODES must be 32..80, step 16");
        if (AXES < 1 || AXES > 16 || TASKS < 1 || TASKS > 16) $error("AXES/TASKS out of range");
    end

    localparam int NXW = NODES / 16 - 1;

    // ----------------------------------------
    // Host control sampling
    // ----------------------------------------
    logic [15:0] ctrl_s1_reg, ctrl_s2_reg, ctrl_s3_reg;
    logic [15:0] rst_s1_reg, rst_s2_reg, rst_s3_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_s1_reg <= '0;
            ctrl_s2_reg <= '0;
            ctrl_s3_reg <= '0;
            rst_s1_reg <= '0;
            rst_s2_reg <= '0;
            rst_s3_reg <= '0;
        end else begin
            ctrl_s1_reg <= ctrl_word;
            ctrl_s2_reg <= ctrl_s1_reg;
            ctrl_s3_reg <= ctrl_s2_reg;
            rst_s1_reg <= restart_bits;
            rst_s2_reg <= rst_s1_reg;
            rst_s3_reg <= rst_s2_reg;
        end
    end

    // Reset requests act on the rising edge only, so a held bit clears once.
    wire err_clr = ctrl_s2_reg[FBEF_B_ERST] & ~ctrl_s3_reg[FBEF_B_ERST];
    wire warn_clr = ctrl_s2_reg[FBEF_B_WRST] & ~ctrl_s3_reg[FBEF_B_WRST];
    wire restart_rise = rst_s2_reg[UNIT_NUM] & ~rst_s3_reg[UNIT_NUM];

    // ----------------------------------------
    // Restart pulse
    // ----------------------------------------
    logic [4:0] rcnt_reg;
    logic unit_restart_reg;
    wire [4:0] rcnt_next = restart_rise ? 5'(FBEF_RESTART_CYC) :
                           (rcnt_reg != 5'h00) ? rcnt_reg - 5'h01 : 5'h00;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rcnt_reg <= 5'h00;
            unit_restart_reg <= 1'b0;
        end else begin
            rcnt_reg <= rcnt_next;
            unit_restart_reg <= (rcnt_next != 5'h00);
        end
    end
    assign unit_restart = unit_restart_reg;
    // Restart also wipes every latched flag so the unit comes back clean.
    wire all_clr = err_clr | unit_restart_reg;
    wire wall_clr = warn_clr | unit_restart_reg;

    // ----------------------------------------
    // Reception timeout counter
    // ----------------------------------------
    logic [7:0] miss_reg;
    wire [7:0] miss_next = !frame_tick ? miss_reg :
                           frame_rx ? 8'h00 :
                           (miss_reg != 8'hFF) ? miss_reg + 8'h01 : miss_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            miss_reg <= 8'h00;
        end else begin
            miss_reg <= miss_next;
        end
    end
    wire tmo_hit = (miss_reg > tmo_limit);

    // ----------------------------------------
    // Network status word
    // ----------------------------------------
    logic [15:0] net_set;
    logic [15:0] net_flags;
    always_comb begin
        net_set = '0;
        net_set[FBEF_B_VERIFY] = (slaves_cfg != slaves_found);
        net_set[FBEF_B_SHAPE] = shape_bad;
        net_set[FBEF_B_PDATA] = pdata_fault;
        net_set[FBEF_B_TMO] = tmo_hit;
        net_set[FBEF_B_PARAM] = param_bad;
        net_set[FBEF_B_SEND] = send_fail;
        net_set[FBEF_B_LINK] = link_fail;
        net_set[FBEF_B_DUP] = dup_addr;
        net_set[FBEF_B_AL] = al_fault;
        net_set[FBEF_B_INIT] = init_fail;
        net_set[FBEF_B_NONFATAL] = pdata_fault & ~pdata_fatal;
        net_set[FBEF_B_FATAL] = pdata_fault & pdata_fatal;
    end

    fbef_latch #(.W(16)) u_net (
        .clock(clock),
        .rst_n(rst_n),
        .set_in(net_set),
        .clr_in(all_clr),
        .flag_out(net_flags)
    );

    // ----------------------------------------
    // Per-node error bits
    // ----------------------------------------
    logic [NODES-1:0] node_flags;
    fbef_latch #(.W(NODES)) u_node (
        .clock(clock),
        .rst_n(rst_n),
        .set_in(node_fault),
        .clr_in(all_clr),
        .flag_out(node_flags)
    );

    // ----------------------------------------
    // Axis and task flags
    // ----------------------------------------
    logic [AXES*4-1:0] axis_eset, axis_eflags;
    logic [AXES-1:0] axis_wflags;
    logic [TASKS*2-1:0] task_eset, task_eflags;
    logic [TASKS-1:0] task_wflags;
    logic [TASKS-1:0] task_busy;
    always_comb begin
        for (int a = 0; a < AXES; a++) begin
            axis_eset[a*4+0] = axis_sensor[a];
            axis_eset[a*4+1] = axis_servo[a];
            axis_eset[a*4+2] = axis_exec[a];
            axis_eset[a*4+3] = axis_err[a];
        end
        for (int t = 0; t < TASKS; t++) begin
            task_eset[t*2+0] = task_exec[t];
            task_eset[t*2+1] = task_err[t];
            task_busy[t] = task_run[t] | |(task_axes[t*AXES +: AXES] & axis_busy);
        end
    end

    fbef_latch #(.W(AXES*4)) u_axe (
        .clock(clock),
        .rst_n(rst_n),
        .set_in(axis_eset),
        .clr_in(all_clr),
        .flag_out(axis_eflags)
    );
    fbef_latch #(.W(AXES)) u_axw (
        .clock(clock),
        .rst_n(rst_n),
        .set_in(axis_warn),
        .clr_in(wall_clr),
        .flag_out(axis_wflags)
    );
    fbef_latch #(.W(TASKS*2)) u_tke (
        .clock(clock),
        .rst_n(rst_n),
        .set_in(task_eset),
        .clr_in(all_clr),
        .flag_out(task_eflags)
    );
    fbef_latch #(.W(TASKS)) u_tkw (
        .clock(clock),
        .rst_n(rst_n),
        .set_in(task_warn),
        .clr_in(wall_clr),
        .flag_out(task_wflags)
    );

    // Busy flags are registered once but never latched.
    logic [AXES-1:0] axis_busy_reg;
    logic [TASKS-1:0] task_busy_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            axis_busy_reg <= '0;
            task_busy_reg <= '0;
        end else begin
            axis_busy_reg <= axis_busy;
            task_busy_reg <= task_busy;
        end
    end

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    wire [15:0] ctrl_base = 16'(FBEF_CTRL_BASE + FBEF_CTRL_STRIDE * {12'h000, UNIT_NUM});
    logic [15:0] rd_mux;
    logic rd_match;
    always_comb begin
        rd_mux = '0;
        rd_match = 1'b0;
        if (rd_addr == 16'(ctrl_base + FBEF_NET_OFS)) begin
            rd_mux = net_flags;
            rd_match = 1'b1;
        end
        if (rd_addr == 16'(ctrl_base + FBEF_NODE1_OFS)) begin
            rd_mux = node_flags[15:0];
            rd_match = 1'b1;
        end
        for (int j = 0; j < NXW; j++) begin
            if (rd_addr == 16'(NODEX_BASE + FBEF_NODEX_OFS + 16'(j))) begin
                rd_mux = node_flags[16*(j+1) +: 16];
                rd_match = 1'b1;
            end
        end
        for (int a = 0; a < AXES; a++) begin
            if (rd_addr == 16'(AXIS_BASE + FBEF_AXIS_BUSY_OFS + FBEF_AXIS_STRIDE * 16'(a))) begin
                rd_mux[FBEF_B_BUSY] = axis_busy_reg[a];
                rd_match = 1'b1;
            end
            if (rd_addr == 16'(AXIS_BASE + FBEF_AXIS_FAULT_OFS + FBEF_AXIS_STRIDE * 16'(a))) begin
                rd_mux[FBEF_B_SENSOR] = axis_eflags[a*4+0];
                rd_mux[FBEF_B_SERVO] = axis_eflags[a*4+1];
                rd_mux[FBEF_B_EXEC] = axis_eflags[a*4+2];
                rd_mux[FBEF_B_WARN] = axis_wflags[a];
                rd_mux[FBEF_B_ERR] = axis_eflags[a*4+3];
                rd_match = 1'b1;
            end
        end
        for (int t = 0; t < TASKS; t++) begin
            if (rd_addr == 16'(TASK_BASE + FBEF_TASK_BUSY_OFS + FBEF_TASK_STRIDE * 16'(t))) begin
                rd_mux[FBEF_B_BUSY] = task_busy_reg[t];
                rd_mux[FBEF_B_EXEC] = task_eflags[t*2+0];
                rd_match = 1'b1;
            end
            if (rd_addr == 16'(TASK_BASE + FBEF_TASK_FAULT_OFS + FBEF_TASK_STRIDE * 16'(t))) begin
                rd_mux[FBEF_B_WARN] = task_wflags[t];
                rd_mux[FBEF_B_ERR] = task_eflags[t*2+1];
                rd_match = 1'b1;
            end
        end
    end

    logic [15:0] rd_data_reg;
    logic rd_hit_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= '0;
            rd_hit_reg <= 1'b0;
        end else begin
            rd_data_reg <= rd_en ? rd_mux : 16'h0000;
            rd_hit_reg <= rd_en & rd_match;
        end
    end
    assign rd_data = rd_data_reg;
    assign rd_hit = rd_hit_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_verify_mismatch: assert property (@(posedge clock) disable iff (!rst_n)
        (slaves_cfg != slaves_found) |=> net_flags[FBEF_B_VERIFY])
        else $error("verify flag missing");
    a_fatal_split: assert property (@(posedge clock) disable iff (!rst_n)
        (pdata_fault && pdata_fatal) |=> net_flags[FBEF_B_FATAL] && net_flags[FBEF_B_PDATA])
        else $error("fatal flag missing");
    a_nonfatal_split: assert property (@(posedge clock) disable iff (!rst_n)
        (pdata_fault && !pdata_fatal) |=> net_flags[FBEF_B_NONFATAL])
        else $error("non-fatal flag missing");
    a_timeout_flag: assert property (@(posedge clock) disable iff (!rst_n)
        (miss_reg > tmo_limit) |=> net_flags[FBEF_B_TMO])
        else $error("timeout flag missing");
    a_error_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (all_clr && net_set == '0) |=> net_flags == '0)
        else $error("error reset ignored");
    a_warn_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (wall_clr && axis_warn == '0) |=> axis_wflags == '0)
        else $error("warning reset ignored");
    a_warn_keep: assert property (@(posedge clock) disable iff (!rst_n)
        (axis_wflags != '0 && !wall_clr) |=> ((~axis_wflags & $past(axis_wflags)) == '0))
        else $error("warning dropped without reset");
    a_task_busy: assert property (@(posedge clock) disable iff (!rst_n)
        (task_run != '0) |=> ((~task_busy_reg & $past(task_run)) == '0))
        else $error("task busy missing");
    a_axis_busy: assert property (@(posedge clock) disable iff (!rst_n)
        (axis_busy == '0) |=> (axis_busy_reg == '0))
        else $error("axis busy latched");
    a_restart_pulse: assert property (@(posedge clock) disable iff (!rst_n)
        restart_rise |=> unit_restart [*8])
        else $error("restart pulse short");
    a_restart_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (unit_restart_reg && net_set == '0) |=> net_flags == '0)
        else $error("restart left flags set");
    a_node_latch: assert property (@(posedge clock) disable iff (!rst_n)
        node_fault[0] |=> node_flags[0])
        else $error("node flag missing");
    a_read_idle: assert property (@(posedge clock) disable iff (!rst_n)
        !rd_en |=> (rd_data == 16'h0000 && !rd_hit))
        else $error("read data without strobe");

    c_restart: cover property (@(posedge clock) disable iff (!rst_n) restart_rise);
    c_err_clr: cover property (@(posedge clock) disable iff (!rst_n) err_clr && net_flags != '0);
    c_timeout: cover property (@(posedge clock) disable iff (!rst_n) tmo_hit);
    c_read_hit: cover property (@(posedge clock) disable iff (!rst_n) rd_hit);
endmodule
`default_nettype wire

/* sim/fbef_host.sv */
// Host controller model that reads status words and pulses control and restart bits.
`timescale 1ns/1ps
`default_nettype none
module fbef_host (
    input wire logic clock, // Unit clock.
    output logic [15:0] ctrl_word, // Error and warning reset bits.
    output logic [15:0] restart_bits, // Restart bits by unit number.
    output logic [15:0] rd_addr, // Word address of a read.
    output logic rd_en // Read strobe.
);
    initial begin
        ctrl_word = 16'h0000;
        restart_bits = 16'h0000;
        rd_addr = 16'h0000;
        rd_en = 1'b0;
    end
    // The address is inverted once the strobe drops, so a stale address never looks valid.
    task automatic rd(input logic [15:0] ad);
        @(posedge clock);
        rd_addr <= ad;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        rd_addr <= ~ad;
    endtask
    // The bit is held four edges because the unit passes it through a two-stage synchronizer.
    task automatic pulse(input logic restart, input int b);
        @(posedge clock);
        if (restart) begin
            restart_bits <= 16'h0001 << b;
        end else begin
            ctrl_word <= 16'h0001 << b;
        end
        repeat (4) @(posedge clock);
        restart_bits <= 16'h0000;
        ctrl_word <= 16'h0000;
        repeat (4) @(posedge clock);
    endtask
endmodule
`default_nettype wire

/* sim/fbef_bank_tb.sv */
// Self-checking bench for the flag bank, driven through the host model.
`timescale 1ns/1ps
`default_nettype none
module fbef_bank_tb;
    import fbef_pkg::*;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    localparam logic [15:0] NET = FBEF_CTRL_BASE + FBEF_NET_OFS;
    localparam logic [15:0] NODE1 = FBEF_CTRL_BASE + FBEF_NODE1_OFS;
    localparam logic [15:0] NODEX = 16'h0300 + FBEF_NODEX_OFS;
    localparam logic [15:0] AXB = 16'h0100;
    localparam logic [15:0] TKB = 16'h0200;
    logic clock, rst_n, unit_restart, rd_hit, rd_en, pdata_fatal, frame_tick, frame_rx, en_q;
    logic [15:0] ctrl_word, restart_bits, rd_addr, rd_data, slaves_cfg, slaves_found, acc, t_axes;
    logic [7:0] nev, tmo_limit;
    logic [79:0] node_fault;
    logic [3:0] a_busy, a_sen, a_srv, a_exe, a_wrn, a_err, t_run, t_exe, t_wrn, t_err;
    logic [16:0] expq[$];
    logic [15:0] nmask[8] = '{16'h0002, 16'h4004, 16'h0010, 16'h0020,
                              16'h0200, 16'h0400, 16'h0800, 16'h1000};
    int bad_count, cmp_count, a, t, k;
    int nodes[3];

    fbef_host host (.clock(clock), .ctrl_word(ctrl_word), .restart_bits(restart_bits),
        .rd_addr(rd_addr), .rd_en(rd_en));
    fbef_bank dut (.clock(clock), .rst_n(rst_n), .ctrl_word(ctrl_word),
        .restart_bits(restart_bits), .rd_addr(rd_addr), .rd_en(rd_en), .rd_data(rd_data),
        .rd_hit(rd_hit), .unit_restart(unit_restart), .slaves_cfg(slaves_cfg),
        .slaves_found(slaves_found), .shape_bad(nev[0]), .pdata_fault(nev[1]),
        .pdata_fatal(pdata_fatal), .frame_tick(frame_tick), .frame_rx(frame_rx),
        .tmo_limit(tmo_limit), .param_bad(nev[2]), .send_fail(nev[3]), .link_fail(nev[4]),
        .dup_addr(nev[5]), .al_fault(nev[6]), .init_fail(nev[7]), .node_fault(node_fault),
        .axis_busy(a_busy), .axis_sensor(a_sen), .axis_servo(a_srv), .axis_exec(a_exe),
        .axis_warn(a_wrn), .axis_err(a_err), .task_axes(t_axes), .task_run(t_run),
        .task_exec(t_exe), .task_warn(t_wrn), .task_err(t_err));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic rdx(input logic [15:0] ad, input logic [15:0] ex, input logic hit);
        expq.push_back({hit, ex});
        host.rd(ad);
    endtask
    task automatic nv(input logic [7:0] v);
        @(posedge clock);
        nev <= v;
        @(posedge clock);
        nev <= 8'h00;
        cyc(2);
    endtask
    task automatic ticks(input int n, input logic got);
        repeat (n) begin
            @(posedge clock);
            frame_tick <= 1'b1;
            frame_rx <= got;
            @(posedge clock);
            frame_tick <= 1'b0;
            frame_rx <= 1'b0;
        end
        cyc(2);
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock, reset, monitor and watchdog
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        rst_n = 1'b0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
    end
    // The oldest note is taken when the answer to a sampled strobe stands.
    always @(posedge clock) begin
        if (en_q && expq.size() > 0) begin
            check({rd_hit, rd_data}, expq.pop_front());
        end
        en_q <= rd_en;
    end
    initial begin
        #(20 * 5000);
        bad_count++;
        conclude();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {pdata_fatal, frame_tick, frame_rx, nev, node_fault} = '0;
        {a_busy, a_sen, a_srv, a_exe, a_wrn, a_err, t_run, t_exe, t_wrn, t_err} = '0;
        {slaves_cfg, slaves_found, t_axes} = '0;
        tmo_limit = 8'h03;
        void'($urandom(32'h4581));
        wait (rst_n === 1'b1);
        cyc(2);
        rdx(NET, 16'h0000, 1'b1);
        rdx(16'h0000, 16'h0000, 1'b0);
        acc = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            nv(8'h01 << i);
            acc = acc | nmask[i];
            rdx(NET, acc, 1'b1);
        end
        @(posedge clock);
        pdata_fatal <= 1'b1;
        nv(8'h02);
        pdata_fatal <= 1'b0;
        rdx(NET, acc | 16'h8004, 1'b1);
        host.pulse(1'b0, FBEF_B_ERST);
        rdx(NET, 16'h0000, 1'b1);
        ticks(3, 1'b0);
        rdx(NET, 16'h0000, 1'b1);
        ticks(1, 1'b0);
        rdx(NET, 16'h0008, 1'b1);
        ticks(1, 1'b1);
        host.pulse(1'b0, FBEF_B_ERST);
        @(posedge clock);
        slaves_cfg <= 16'($urandom);
        cyc(1);
        slaves_found <= slaves_cfg + 16'h0001;
        cyc(1);
        slaves_found <= slaves_cfg;
        cyc(2);
        rdx(NET, 16'h0001, 1'b1);
        host.pulse(1'b0, FBEF_B_ERST);
        rdx(NET, 16'h0000, 1'b1);
        nodes = '{0, 79, int'($urandom % 80)};
        foreach (nodes[i]) begin
            @(posedge clock);
            node_fault <= 80'h1 << nodes[i];
            @(posedge clock);
            node_fault <= '0;
            cyc(2);
            if (nodes[i] < 16) begin
                rdx(NODE1, 16'h0001 << nodes[i], 1'b1);
            end else begin
                rdx(NODEX + 16'((nodes[i] - 16) / 16), 16'h0001 << ((nodes[i] - 16) % 16), 1'b1);
            end
            host.pulse(1'b0, FBEF_B_ERST);
        end
        a = $urandom % 4;
        t = $urandom % 4;
        @(posedge clock);
        t_axes <= 16'h0001 << (t * 4 + a);
        a_busy <= 4'h1 << a;
        cyc(3);
        rdx(AXB + 16'(2 + 13 * a), 16'h0001, 1'b1);
        rdx(TKB + 16'(1 + 6 * t), 16'h0001, 1'b1);
        a_busy <= 4'h0;
        t_run <= 4'h1 << t;
        cyc(3);
        rdx(AXB + 16'(2 + 13 * a), 16'h0000, 1'b1);
        rdx(TKB + 16'(1 + 6 * t), 16'h0001, 1'b1);
        t_run <= 4'h0;
        {a_sen, a_srv, a_exe, a_wrn, a_err} <= {5{4'h1 << a}};
        {t_exe, t_wrn, t_err} <= {3{4'h1 << t}};
        @(posedge clock);
        {a_sen, a_srv, a_exe, a_wrn, a_err, t_exe, t_wrn, t_err} <= '0;
        cyc(3);
        rdx(AXB + 16'(5 + 13 * a), 16'h1F00, 1'b1);
        rdx(TKB + 16'(1 + 6 * t), 16'h0400, 1'b1);
        rdx(TKB + 16'(2 + 6 * t), 16'h1800, 1'b1);
        host.pulse(1'b0, FBEF_B_WRST);
        rdx(AXB + 16'(5 + 13 * a), 16'h1700, 1'b1);
        rdx(TKB + 16'(2 + 6 * t), 16'h1000, 1'b1);
        host.pulse(1'b0, FBEF_B_ERST);
        rdx(AXB + 16'(5 + 13 * a), 16'h0000, 1'b1);
        rdx(TKB + 16'(1 + 6 * t), 16'h0000, 1'b1);
        rdx(TKB + 16'(2 + 6 * t), 16'h0000, 1'b1);
        nv(8'h01);
        host.pulse(1'b1, 1);
        #1;
        check({16'h0000, unit_restart}, 17'h00000);
        rdx(NET, 16'h0002, 1'b1);
        k = 0;
        fork
            host.pulse(1'b1, 0);
            repeat (40) begin
                @(posedge clock);
                #1;
                if (unit_restart === 1'b1) begin
                    k++;
                end
            end
        join
        check(17'(k), 17'(FBEF_RESTART_CYC));
        rdx(NET, 16'h0000, 1'b1);
        cyc(4);
        check(17'(expq.size()), 17'h00000);
        conclude();
    end
endmodule
`default_nettype wire
